// >>> pdepm_defs.vh
// Offsets, field positions, reset values and codes of the D/E port mux
`ifndef PDEPM_DEFS_VH
`define PDEPM_DEFS_VH

// Byte addresses of the registers on the AXI4-Lite bus
`define PDEPM_A_DPIN 8'h00
`define PDEPM_A_DLAT 8'h04
`define PDEPM_A_DDIR 8'h08
`define PDEPM_A_GCTL 8'h0C
`define PDEPM_A_EPIN 8'h10
`define PDEPM_A_ELAT 8'h14
`define PDEPM_A_EDIR 8'h18
`define PDEPM_A_MEMC 8'h1C
`define PDEPM_A_PSPC 8'h20
`define PDEPM_A_CFG 8'h24

// Register indices returned by the address decoder
`define PDEPM_I_DPIN 4'h0
`define PDEPM_I_DLAT 4'h1
`define PDEPM_I_DDIR 4'h2
`define PDEPM_I_GCTL 4'h3
`define PDEPM_I_EPIN 4'h4
`define PDEPM_I_ELAT 4'h5
`define PDEPM_I_EDIR 4'h6
`define PDEPM_I_MEMC 4'h7
`define PDEPM_I_PSPC 4'h8
`define PDEPM_I_CFG 4'h9
`define PDEPM_I_NONE 4'hF

// Field positions
`define PDEPM_B_DPU 7
`define PDEPM_B_EPU 6
`define PDEPM_B_JPU 5
`define PDEPM_B_EXT_BUS_DISABLE 7
`define PDEPM_B_PSPEN 4
`define PDEPM_B_PWM13 0
`define PDEPM_B_PWM2 1
`define PDEPM_B_MCU 2

// Reset values
`define PDEPM_R_DIR 8'hFF
`define PDEPM_R_LAT 8'h00
`define PDEPM_R_GCTL 8'h00
`define PDEPM_R_MEMC 8'h80
`define PDEPM_R_PSPC 8'h00
`define PDEPM_R_CFG 3'h7

// Bus responses
`define PDEPM_OKAY 2'h0
`define PDEPM_SLVERR 2'h2

`endif

// >>> pdepm_port_mux.v
// Port D / Port E pin multiplexer with AXI4-Lite register slave
`timescale 1ns/10ps
`include "pdepm_defs.vh"
module pdepm_port_mux #(
    parameter [0:0] PKG80 = 1'h1
) (
    input wire clk,
    input wire rstn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] dPinIn,
    output wire [7:0] dPinOut,
    output wire [7:0] dPinOe,
    output wire [7:0] dPullupOn,
    input wire [7:0] ePinIn,
    output wire [7:0] ePinOut,
    output wire [7:0] ePinOe,
    output wire [7:0] ePullupOn,
    input wire [15:0] extBusOut,
    input wire [15:0] extBusOe,
    output wire [15:0] extBusIn,
    input wire parallelSlaveRead,
    output wire [7:0] parallelSlaveData,
    output wire [2:0] parallelSlaveCtlIn,
    input wire spiClock2Drive,
    input wire spiClock2Out,
    input wire i2cMode2,
    input wire i2cClock2Low,
    output wire serialClock2In,
    output wire i2cBufferSel2,
    output wire slaveSelect2,
    input wire [3:0] pwm13BcOut,
    input wire [3:0] pwm13BcEn,
    input wire [2:0] pwm2BcdOut,
    input wire [2:0] pwm2BcdEn,
    input wire pwm2AOut,
    input wire pwm2AEn,
    output wire [3:0] hPwmOut,
    output wire [3:0] hPwmOe
);

    // Register file
    reg [7:0] dLat_r;
    reg [7:0] dDir_r;
    reg [2:0] gCtl_r;
    reg [7:0] eLat_r;
    reg [7:0] eDir_r;
    reg memCtl_r;
    reg pspCtl_r;
    reg [2:0] cfg_r;
    // Bus state
    reg awHeld_r;
    reg [7:0] awAddr_r;
    reg wHeld_r;
    reg [7:0] wData_r;
    reg wStrb_r;
    reg awReady_r;
    reg wReady_r;
    reg bValid_r;
    reg [1:0] bResp_r;
    reg arReady_r;
    reg rValid_r;
    reg [31:0] rData_r;
    reg [1:0] rResp_r;
    // Pin side
    reg [7:0] dPin_r, ePin_r, dOut_r, dOe_r, dPu_r, pspData_r;
    reg [7:0] eOut_r, eOe_r, ePu_r;
    reg [3:0] hOut_r, hOe_r;
    reg [15:0] busIn_r;
    reg [2:0] pspCtlIn_r;
    reg sck2In_r, i2cSel_r, ss2_r;
    reg [7:0] dOut_nxt, dOe_nxt, eOut_nxt, eOe_nxt, rdMux_nxt;
    reg [3:0] hOut_nxt, hOe_nxt;

    wire awTake, wTake, doWr, awHeldN, wHeldN, bValidN;
    wire arTake, rValidN, busOn, pwm13OnE, pwm2AOnE;
    wire [3:0] wrIdx, rdIdx;
    integer i;
    integer j;

    // Reset images, so single fields can be picked out of them
    localparam [7:0] GCTL_RST = `PDEPM_R_GCTL;
    localparam [7:0] MEMC_RST = `PDEPM_R_MEMC;
    localparam [7:0] PSPC_RST = `PDEPM_R_PSPC;

    // Byte address to register index
    function [3:0] regIdx;
        input [7:0] addr;
        begin
            case (addr)
                `PDEPM_A_DPIN: regIdx = `PDEPM_I_DPIN;
                `PDEPM_A_DLAT: regIdx = `PDEPM_I_DLAT;
                `PDEPM_A_DDIR: regIdx = `PDEPM_I_DDIR;
                `PDEPM_A_GCTL: regIdx = `PDEPM_I_GCTL;
                `PDEPM_A_EPIN: regIdx = `PDEPM_I_EPIN;
                `PDEPM_A_ELAT: regIdx = `PDEPM_I_ELAT;
                `PDEPM_A_EDIR: regIdx = `PDEPM_I_EDIR;
                `PDEPM_A_MEMC: regIdx = `PDEPM_I_MEMC;
                `PDEPM_A_PSPC: regIdx = `PDEPM_I_PSPC;
                `PDEPM_A_CFG: regIdx = `PDEPM_I_CFG;
                default: regIdx = `PDEPM_I_NONE;
            endcase
        end
    endfunction

    // Handshake terms of the bus
    assign awTake = s_axi_awvalid & awReady_r;
    assign wTake = s_axi_wvalid & wReady_r;
    assign doWr = awHeld_r & wHeld_r;
    assign awHeldN = (awHeld_r | awTake) & ~doWr;
    assign wHeldN = (wHeld_r | wTake) & ~doWr;
    assign bValidN = doWr | (bValid_r & ~s_axi_bready);
    assign arTake = s_axi_arvalid & arReady_r;
    assign rValidN = arTake | (rValid_r & ~s_axi_rready);
    assign wrIdx = regIdx(awAddr_r);
    assign rdIdx = regIdx(s_axi_araddr);

    // Bus active only on the large package with the bus enabled
    assign busOn = PKG80 & ~memCtl_r;
    assign pwm13OnE = ~PKG80 | cfg_r[`PDEPM_B_PWM13];
    assign pwm2AOnE = cfg_r[`PDEPM_B_MCU] & ~cfg_r[`PDEPM_B_PWM2];

    // Write channel capture and response
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awHeld_r <= 1'h0;
            awAddr_r <= 8'h00;
            wHeld_r <= 1'h0;
            wData_r <= 8'h00;
            wStrb_r <= 1'h0;
            awReady_r <= 1'h0;
            wReady_r <= 1'h0;
            bValid_r <= 1'h0;
            bResp_r <= `PDEPM_OKAY;
        end else begin
            awHeld_r <= awHeldN;
            wHeld_r <= wHeldN;
            bValid_r <= bValidN;
            awReady_r <= ~awHeldN & ~bValidN;
            wReady_r <= ~wHeldN & ~bValidN;
            if (awTake) begin
                awAddr_r <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_r <= s_axi_wdata[7:0];
                wStrb_r <= s_axi_wstrb[0];
            end
            if (doWr) begin
                if (wrIdx == `PDEPM_I_NONE) begin
                    bResp_r <= `PDEPM_SLVERR;
                end else begin
                    bResp_r <= `PDEPM_OKAY;
                end
            end
        end
    end

    // Register writes; only byte lane 0 carries data
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dLat_r <= `PDEPM_R_LAT;
            dDir_r <= `PDEPM_R_DIR;
            gCtl_r <= GCTL_RST[7:5];
            eLat_r <= `PDEPM_R_LAT;
            eDir_r <= `PDEPM_R_DIR;
            memCtl_r <= MEMC_RST[`PDEPM_B_EXT_BUS_DISABLE];
            pspCtl_r <= PSPC_RST[`PDEPM_B_PSPEN];
            cfg_r <= `PDEPM_R_CFG;
        end else if (doWr && wStrb_r) begin
            case (wrIdx)
                `PDEPM_I_DPIN: dLat_r <= wData_r;
                `PDEPM_I_DLAT: dLat_r <= wData_r;
                `PDEPM_I_DDIR: dDir_r <= wData_r;
                `PDEPM_I_GCTL: begin
                    gCtl_r[2] <= wData_r[`PDEPM_B_DPU];
                    gCtl_r[1] <= wData_r[`PDEPM_B_EPU];
                    gCtl_r[0] <= wData_r[`PDEPM_B_JPU] & PKG80;
                end
                `PDEPM_I_EPIN: eLat_r <= wData_r;
                `PDEPM_I_ELAT: eLat_r <= wData_r;
                `PDEPM_I_EDIR: eDir_r <= wData_r;
                `PDEPM_I_MEMC: memCtl_r <= wData_r[`PDEPM_B_EXT_BUS_DISABLE];
                `PDEPM_I_PSPC: pspCtl_r <= wData_r[`PDEPM_B_PSPEN];
                `PDEPM_I_CFG: cfg_r <= wData_r[2:0];
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // Read data selection
    always @* begin
        rdMux_nxt = 8'h00;
        case (rdIdx)
            `PDEPM_I_DPIN: rdMux_nxt = dPin_r;
            `PDEPM_I_DLAT: rdMux_nxt = dLat_r;
            `PDEPM_I_DDIR: rdMux_nxt = dDir_r;
            `PDEPM_I_GCTL: rdMux_nxt = {gCtl_r[2:1],
                gCtl_r[0] & PKG80, 5'h00};
            `PDEPM_I_EPIN: rdMux_nxt = ePin_r;
            `PDEPM_I_ELAT: rdMux_nxt = eLat_r;
            `PDEPM_I_EDIR: rdMux_nxt = eDir_r;
            `PDEPM_I_MEMC: rdMux_nxt = {memCtl_r, 7'h00};
            `PDEPM_I_PSPC: rdMux_nxt = {3'h0, pspCtl_r, 4'h0};
            `PDEPM_I_CFG: rdMux_nxt = {5'h00, cfg_r};
            default: rdMux_nxt = 8'h00;
        endcase
    end

    // Read channel
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arReady_r <= 1'h0;
            rValid_r <= 1'h0;
            rData_r <= 32'h0000_0000;
            rResp_r <= `PDEPM_OKAY;
        end else begin
            rValid_r <= rValidN;
            arReady_r <= ~rValidN;
            if (arTake) begin
                rData_r <= {24'h00_0000, rdMux_nxt};
                if (rdIdx == `PDEPM_I_NONE) begin
                    rResp_r <= `PDEPM_SLVERR;
                end else begin
                    rResp_r <= `PDEPM_OKAY;
                end
            end
        end
    end

    // Port D drive priority per pin
    always @* begin
        dOut_nxt = 8'h00;
        dOe_nxt = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (busOn) begin
                dOut_nxt[i] = extBusOut[i];
                dOe_nxt[i] = extBusOe[i];
            end else if (pspCtl_r) begin
                dOut_nxt[i] = dLat_r[i];
                dOe_nxt[i] = parallelSlaveRead;
            end else if (i == 6 && i2cMode2) begin
                dOut_nxt[i] = 1'h0;
                dOe_nxt[i] = i2cClock2Low & ~dDir_r[6];
            end else if (i == 6 && spiClock2Drive && !dDir_r[6]) begin
                dOut_nxt[i] = spiClock2Out;
                dOe_nxt[i] = 1'h1;
            end else begin
                dOut_nxt[i] = dLat_r[i];
                dOe_nxt[i] = ~dDir_r[i];
            end
        end
    end

    // Port E drive priority and PWM routing
    always @* begin
        eOut_nxt = eLat_r;
        eOe_nxt = ~eDir_r;
        hOut_nxt = 4'h0;
        hOe_nxt = 4'h0;
        if (busOn) begin
            eOut_nxt = extBusOut[15:8];
            eOe_nxt = extBusOe[15:8];
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                if (pwm13OnE) begin
                    if (pwm13BcEn[j]) begin
                        eOut_nxt[6 - j] = pwm13BcOut[j];
                        eOe_nxt[6 - j] = 1'h1;
                    end
                end else begin
                    hOut_nxt[j] = pwm13BcOut[j];
                    hOe_nxt[j] = pwm13BcEn[j];
                end
            end
            for (j = 0; j < 3; j = j + 1) begin
                if (pwm2BcdEn[j]) begin
                    eOut_nxt[2 - j] = pwm2BcdOut[j];
                    eOe_nxt[2 - j] = 1'h1;
                end
            end
            if (pwm2AOnE && pwm2AEn) begin
                eOut_nxt[7] = pwm2AOut;
                eOe_nxt[7] = 1'h1;
            end
            if (pspCtl_r) begin
                // Control inputs; E2:0 forced to inputs whatever their direction bits
                eOe_nxt[2:0] = 3'h0;
            end
        end
    end

    // Pin flops, pull-ups and peripheral inputs
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dPin_r <= 8'h00;
            ePin_r <= 8'h00;
            dOut_r <= 8'h00;
            dOe_r <= 8'h00;
            dPu_r <= 8'h00;
            eOut_r <= 8'h00;
            eOe_r <= 8'h00;
            ePu_r <= 8'h00;
            hOut_r <= 4'h0;
            hOe_r <= 4'h0;
            busIn_r <= 16'h0000;
            pspData_r <= 8'h00;
            pspCtlIn_r <= 3'h0;
            sck2In_r <= 1'h0;
            i2cSel_r <= 1'h0;
            ss2_r <= 1'h0;
        end else begin
            dPin_r <= dPinIn;
            ePin_r <= ePinIn;
            dOut_r <= dOut_nxt;
            dOe_r <= dOe_nxt;
            dPu_r <= {8{gCtl_r[2]}} & ~dOe_nxt;
            eOut_r <= eOut_nxt;
            eOe_r <= eOe_nxt;
            ePu_r <= {8{gCtl_r[1]}} & ~eOe_nxt;
            hOut_r <= hOut_nxt;
            hOe_r <= hOe_nxt;
            busIn_r <= busOn ? {ePinIn, dPinIn} : 16'h0000;
            pspData_r <= dPinIn;
            pspCtlIn_r <= ePinIn[2:0];
            sck2In_r <= dPinIn[6];
            i2cSel_r <= i2cMode2;
            ss2_r <= dPinIn[7];
        end
    end

    // Output connections
    assign s_axi_awready = awReady_r;
    assign s_axi_wready = wReady_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;
    assign s_axi_rvalid = rValid_r;
    assign dPinOut = dOut_r;
    assign dPinOe = dOe_r;
    assign dPullupOn = dPu_r;
    assign ePinOut = eOut_r;
    assign ePinOe = eOe_r;
    assign ePullupOn = ePu_r;
    assign extBusIn = busIn_r;
    assign parallelSlaveData = pspData_r;
    assign parallelSlaveCtlIn = pspCtlIn_r;
    assign serialClock2In = sck2In_r;
    assign i2cBufferSel2 = i2cSel_r;
    assign slaveSelect2 = ss2_r;
    assign hPwmOut = hOut_r;
    assign hPwmOe = hOe_r;

endmodule

// >>> pdepm_port_mux_chk.sv
// Port-level assertions for the D/E pin multiplexer
`timescale 1ns/10ps
module pdepm_port_mux_chk (
    input wire clk,
    input wire rstn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] dPinIn,
    input wire [7:0] dPinOut,
    input wire [7:0] dPinOe,
    input wire [7:0] dPullupOn,
    input wire [7:0] ePinOut,
    input wire [7:0] ePinOe,
    input wire [7:0] ePullupOn,
    input wire [15:0] extBusOut,
    input wire [15:0] extBusOe,
    input wire [15:0] extBusIn,
    input wire i2cMode2,
    input wire i2cBufferSel2,
    input wire serialClock2In,
    input wire slaveSelect2
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Port E floats as plain inputs right after reset
    chk_reset_quiet: assert property (
        $past(rstn) == 1'h0 |-> ePinOe == 8'h00 && ePullupOn == 8'h00)
        else $error("Port E not idle after reset");
    // Bus owns every pin while it runs
    chk_bus_drive: assert property (
        extBusIn != 16'h0000 |-> {ePinOe, dPinOe} == $past(extBusOe) &&
        ({ePinOut, dPinOut} & {ePinOe, dPinOe}) ==
        ($past(extBusOut) & $past(extBusOe)))
        else $error("Bus drive not on pins");
    // No pull-up on a driven pin
    chk_pullup_drive: assert property (
        (ePullupOn & ePinOe) == 8'h00 && (dPullupOn & dPinOe) == 8'h00)
        else $error("Pull-up on while driving");
    // Slave select follows D7 whatever its direction
    chk_slave_select: assert property (
        $past(rstn) |-> slaveSelect2 == $past(dPinIn[7]))
        else $error("Slave select not from D7");
    // Serial clock input taken from D6
    chk_sclk_input: assert property (
        $past(rstn) |-> serialClock2In == $past(dPinIn[6]))
        else $error("Serial clock input not from D6");
    // Input buffer type follows serial mode
    chk_i2c_buffer: assert property (
        $past(rstn) |-> i2cBufferSel2 == $past(i2cMode2))
        else $error("Buffer select not following mode");
    // Write answered two cycles after address and data
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("Write response timing wrong");
    // Read answered on the next cycle
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late");
    // Read channel reopens once data is taken
    chk_read_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("Read channel not released");
endmodule

bind pdepm_port_mux pdepm_port_mux_chk chk (.*);

// >>> pdepm_board.sv
// Board model: pin levels from chip drive, outside drivers and pulls
`timescale 1ns/10ps
module pdepm_board (
    input wire clk,
    input wire [7:0] pinOut,
    input wire [7:0] pinOe,
    input wire [7:0] pullOn,
    input wire [7:0] extVal,
    input wire [7:0] extEn,
    output logic [7:0] pinLvl
);
    integer i;
    initial pinLvl = 8'h00;
    // Chip drive first, then outside driver, pull-up, else drifting
    always @(posedge clk) begin
        for (i = 0; i < 8; i = i + 1) begin
            if (pinOe[i]) begin
                pinLvl[i] <= pinOut[i];
            end else if (extEn[i]) begin
                pinLvl[i] <= extVal[i];
            end else if (pullOn[i]) begin
                pinLvl[i] <= 1'h1;
            end else begin
                pinLvl[i] <= ~pinLvl[i];
            end
        end
    end
endmodule

// >>> test_port_d_e_pin_mux.sv
// Self-checking bench for the D/E pin multiplexer
`timescale 1ns/10ps
`include "pdepm_defs.vh"
module test_port_d_e_pin_mux;
    logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, parallelSlaveRead;
    logic spiClock2Drive, spiClock2Out, i2cMode2, i2cClock2Low;
    logic serialClock2In, i2cBufferSel2, slaveSelect2, pwm2AOut, pwm2AEn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, dPinIn, dPinOut, dPinOe;
    logic [7:0] dPullupOn, ePinIn, ePinOut, ePinOe, ePullupOn;
    logic [7:0] parallelSlaveData, dExt, dExtEn, eExt, eExtEn;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [15:0] extBusOut, extBusOe, extBusIn;
    logic [3:0] s_axi_wstrb, pwm13BcOut, pwm13BcEn, hPwmOut, hPwmOe;
    logic [2:0] parallelSlaveCtlIn, pwm2BcdOut, pwm2BcdEn;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] rdata64;
    logic [7:0] ePinOe64;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    pdepm_port_mux #(.PKG80(1'h1)) uut (.*);
    pdepm_board boardD (.clk(clk), .pinOut(dPinOut), .pinOe(dPinOe),
        .pullOn(dPullupOn), .extVal(dExt), .extEn(dExtEn), .pinLvl(dPinIn));
    pdepm_board boardE (.clk(clk), .pinOut(ePinOut), .pinOe(ePinOe),
        .pullOn(ePullupOn), .extVal(eExt), .extEn(eExtEn), .pinLvl(ePinIn));
    // Small-package copy on the same bus and pins: no bus, no J pull-up
    pdepm_port_mux #(.PKG80(1'h0)) uut64 (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
        .s_axi_rdata(rdata64), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(s_axi_rready), .dPinIn(dPinIn), .dPinOut(),
        .dPinOe(), .dPullupOn(), .ePinIn(ePinIn), .ePinOut(),
        .ePinOe(ePinOe64), .ePullupOn(), .extBusOut(extBusOut),
        .extBusOe(extBusOe), .extBusIn(),
        .parallelSlaveRead(parallelSlaveRead), .parallelSlaveData(),
        .parallelSlaveCtlIn(), .spiClock2Drive(spiClock2Drive),
        .spiClock2Out(spiClock2Out), .i2cMode2(i2cMode2),
        .i2cClock2Low(i2cClock2Low), .serialClock2In(),
        .i2cBufferSel2(), .slaveSelect2(), .pwm13BcOut(pwm13BcOut),
        .pwm13BcEn(pwm13BcEn), .pwm2BcdOut(pwm2BcdOut),
        .pwm2BcdEn(pwm2BcdEn), .pwm2AOut(pwm2AOut), .pwm2AEn(pwm2AEn),
        .hPwmOut(), .hPwmOe());

    always #12.5 clk = ~clk;

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    // Bus read with expected data and response
    task automatic rd(input logic [7:0] a, exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk("rdata", {24'h0, exp}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, parallelSlaveRead,
            spiClock2Drive, spiClock2Out, i2cMode2, i2cClock2Low,
            pwm2AOut, pwm2AEn, clk, rstn} = '0;
        {extBusOut, extBusOe, pwm13BcOut, pwm13BcEn, pwm2BcdOut,
            pwm2BcdEn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        {dExt, dExtEn, eExt, eExtEn} = 32'h3C0F_550F;
        step(3);
        rstn <= 1'h1;
        step(2);
        chk("ePinOe", 8'h00, ePinOe);
        chk("ePullupOn", 8'h00, ePullupOn);
        chk("dPinOe", 8'h00, dPinOe);
        rd(`PDEPM_A_DDIR, 8'hFF, `PDEPM_OKAY);
        rd(`PDEPM_A_EDIR, 8'hFF, `PDEPM_OKAY);
        rd(`PDEPM_A_GCTL, 8'h00, `PDEPM_OKAY);
        rd(`PDEPM_A_MEMC, 8'h80, `PDEPM_OKAY);
        rd(`PDEPM_A_PSPC, 8'h00, `PDEPM_OKAY);
        rd(`PDEPM_A_CFG, 8'h07, `PDEPM_OKAY);
        rd(8'h28, 8'h00, `PDEPM_SLVERR);
        wr(8'h28, 8'h5A, `PDEPM_SLVERR);
        // Port D latch and direction
        wr(`PDEPM_A_DPIN, 8'hA5, `PDEPM_OKAY);
        wr(`PDEPM_A_DDIR, 8'h0F, `PDEPM_OKAY);
        step(3);
        chk("dPinOe", 8'hF0, dPinOe);
        chk("dPinOut", 8'hA0, dPinOut & dPinOe);
        rd(`PDEPM_A_DLAT, 8'hA5, `PDEPM_OKAY);
        rd(`PDEPM_A_DPIN, 8'hAC, `PDEPM_OKAY);
        // Port E latch and direction, E3:0 left as inputs
        wr(`PDEPM_A_ELAT, 8'h33, `PDEPM_OKAY);
        wr(`PDEPM_A_EDIR, 8'h0F, `PDEPM_OKAY);
        step(3);
        chk("ePinOe", 8'hF0, ePinOe);
        chk("ePinOut", 8'h30, ePinOut & ePinOe);
        rd(`PDEPM_A_ELAT, 8'h33, `PDEPM_OKAY);
        rd(`PDEPM_A_EPIN, 8'h35, `PDEPM_OKAY);
        // Pull-ups
        wr(`PDEPM_A_GCTL, 8'hE0, `PDEPM_OKAY);
        rd(`PDEPM_A_GCTL, 8'hE0, `PDEPM_OKAY);
        chk("gctl64", 8'hC0, rdata64);
        chk("ePullupOn", 8'h0F, ePullupOn);
        chk("dPullupOn", 8'h0F, dPullupOn);
        wr(`PDEPM_A_GCTL, 8'h80, `PDEPM_OKAY);
        step(2);
        chk("ePullupOn", 8'h00, ePullupOn);
        // PWM routing
        pwm13BcEn <= 4'hF;
        pwm13BcOut <= 4'hA;
        pwm2BcdEn <= 3'h7;
        pwm2BcdOut <= 3'h5;
        step(3);
        chk("ePinOe", 8'hFF, ePinOe);
        chk("ePinOut", 8'h2D, ePinOut & 8'h7F);
        chk("hPwmOe", 4'h0, hPwmOe);
        wr(`PDEPM_A_CFG, 8'h06, `PDEPM_OKAY);
        step(2);
        chk("hPwmOe", 4'hF, hPwmOe);
        chk("hPwmOut", 4'hA, hPwmOut);
        chk("ePinOe", 8'hF7, ePinOe);
        pwm2AEn <= 1'h1;
        pwm2AOut <= 1'h1;
        wr(`PDEPM_A_CFG, 8'h04, `PDEPM_OKAY);
        step(2);
        chk("ePinOut7", 8'h80, ePinOut & ePinOe & 8'h80);
        // Parallel slave port
        wr(`PDEPM_A_PSPC, 8'h10, `PDEPM_OKAY);
        step(4);
        chk("ePinOe", 8'h00, ePinOe & 8'h07);
        chk("psCtl", 3'h5, parallelSlaveCtlIn);
        chk("psData", 8'hFC, parallelSlaveData);
        parallelSlaveRead <= 1'h1;
        step(2);
        chk("dPinOe", 8'hFF, dPinOe);
        chk("dPinOut", 8'hA5, dPinOut);
        parallelSlaveRead <= 1'h0;
        wr(`PDEPM_A_PSPC, 8'h00, `PDEPM_OKAY);
        // Serial port on D6 and D7
        spiClock2Drive <= 1'h1;
        spiClock2Out <= 1'h1;
        step(2);
        chk("spiClk", 8'h40, dPinOut & dPinOe & 8'h40);
        spiClock2Drive <= 1'h0;
        i2cMode2 <= 1'h1;
        i2cClock2Low <= 1'h1;
        step(3);
        chk("i2cClk", 8'h40, ~dPinOut & dPinOe & 8'h40);
        chk("bufSel", 1'h1, i2cBufferSel2);
        chk("slaveSel", 1'h1, slaveSelect2);
        // External bus takes both ports
        extBusOut <= 16'h1234;
        extBusOe <= 16'h0FF0;
        wr(`PDEPM_A_MEMC, 8'h00, `PDEPM_OKAY);
        step(2);
        chk("dPinOe", 8'hF0, dPinOe);
        chk("ePinOe", 8'h0F, ePinOe);
        chk("ePinOut", 8'h02, ePinOut & ePinOe);
        chk("ePinOe64", 8'hFF, ePinOe64);
        wr(`PDEPM_A_MEMC, 8'h80, `PDEPM_OKAY);
        step(2);
        chk("ePinOe", 8'hF7, ePinOe);
        stop_test();
    end
endmodule
